// ### idr_host_model.sv
// idr_host_model: apb host that issues identify and reads the block.
// assumes an apb slave on pclk that answers with pready.
`timescale 1ns/1ps
module idr_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ==========================================================================
  // bus idle at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================================
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released address and data show inverted values, never the last request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // ==========================================================================
  // opcode with the drive bit at position 12 of the command word
  task automatic identify(input logic drv, input logic [7:0] op);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, idr_pkg::IDR_CMD_OFS, {19'h0, drv, 4'h0, op}, rd, err);
  endtask
endmodule

// ### idr_identify.sv
// idr_identify: answers the identify command with a 256-word parameter block
// read over the data port like a single-sector read.
// assumes an apb master on pclk; card values are loaded by software first.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// R1: identify opcode to matching drive starts preparation
// R2: busy, then data request, then 256 reads
// R3: reserved bits and words return zero
// R4: host must not trust obsolete words zero
// R5: words 80 and 81 return zero
// R6: sectors per card, word 7 high half
// R7: current capacity, word 57 low half
// R8: word 22 returns four ecc bytes
// R9: firmware text words 23-26, high byte first
// R10: model text words 27-46, left justified
// R11: serial text words 10-19, right justified
// R12: word 59 high byte one, current setting low
// R13: pc card modes zero words 63,65,66
// R14: word 0 flag only 8h or 0h
// R15: flag zero sets word 83 bit 2
// R16: alternate word 0 values 044ah or 0040h; media bit set gives 04cah or 00c0h
// R17: pc card modes return signature only
// R18: retired bits 11:8 are 0h or 4h
// R19: word 0 bit 7 shows removable media
// R20: word 0 bit 6 shows fixed device
// R21: fixed zero bytes in words 3,49,51,64
// R22: host may need bit 6 set for root
// R23: bits 5:0 are 00h or 0ah, bits 2,0 zero
module idr_identify #(
  parameter logic [15:0]  SIGNATURE = 16'h8123, // arbitrary neutral value, flag 8h
  parameter logic [159:0] SERIAL    = {"            ", "00000001"},
  parameter logic [63:0]  FIRMWARE  = "REV 1.00",
  parameter logic [319:0] MODEL     = {"FLASH STORAGE CARD", {22{8'h20}}},
  parameter logic [15:0]  PIO_CYC_NOFC = 16'h0078, // word 67
  parameter logic [15:0]  PIO_CYC_FC   = 16'h0078  // word 68
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             data_req
);

  // ==========================================================================
  // state and registers
  idr_pkg::idr_state_t state_r;      // transfer state
  idr_pkg::idr_state_t state_nxt;
  logic [7:0]  idx_r;                 // next word to deliver
  logic [7:0]  idx_nxt;
  logic [3:0]  prep_r;                // preparation countdown
  logic [3:0]  prep_nxt;
  logic        err_r;                 // last command refused
  logic        err_nxt;
  logic [7:0]  cfg_r;                 // configuration
  logic [31:0] cap_r;                 // sectors per card
  logic [15:0] cyl_r;                 // cylinders
  logic [31:0] geom_r;                // heads 7:0, sectors per track 31:16
  logic [31:0] mult_r;                // max mult, current mult, pio, adv pio
  logic [31:0] dma_r;                 // word 63 low half, cycle time high half
  logic [31:0] prdata_r;              // read data, loaded in setup cycle
  logic        pready_r;              // zero-wait answer
  logic        pslverr_r;             // unmapped address
  logic        busy_r;
  logic        drq_r;

  // ==========================================================================
  // apb decode
  wire setup_w    = psel & ~penable;                 // setup cycle of a transfer
  wire done_w     = psel & penable & pready_r;       // completing access edge
  wire hit_cmd    = (paddr == idr_pkg::IDR_CMD_OFS);
  wire hit_stat   = (paddr == idr_pkg::IDR_STAT_OFS);
  wire hit_data   = (paddr == idr_pkg::IDR_DATA_OFS);
  wire hit_cfg    = (paddr == idr_pkg::IDR_CFG_OFS);
  wire hit_cap    = (paddr == idr_pkg::IDR_CAP_OFS);
  wire hit_cyl    = (paddr == idr_pkg::IDR_CYL_OFS);
  wire hit_geom   = (paddr == idr_pkg::IDR_GEOM_OFS);
  wire hit_mult   = (paddr == idr_pkg::IDR_MULT_OFS);
  wire hit_dma    = (paddr == idr_pkg::IDR_DMA_OFS);
  wire mapped_w   = hit_cmd | hit_stat | hit_data | hit_cfg | hit_cap
                  | hit_cyl | hit_geom | hit_mult | hit_dma;
  wire wr_w       = done_w & pwrite & mapped_w;      // write takes effect here
  wire pop_w      = done_w & ~pwrite & hit_data & drq_r; // word consumed

  // ==========================================================================
  // configuration fields
  wire       drive_id  = cfg_r[idr_pkg::IDR_CFG_DRIVE_BIT];
  wire [1:0] mode_w    = cfg_r[idr_pkg::IDR_CFG_MODE_LSB +: 2];
  wire       alt_en    = cfg_r[idr_pkg::IDR_CFG_ALT_BIT];
  wire       keep_ret  = cfg_r[idr_pkg::IDR_CFG_KEEP_BIT];
  wire       media_rem = cfg_r[idr_pkg::IDR_CFG_MEDIA_BIT];
  wire       pccard_w  = (mode_w != idr_pkg::IDR_MODE_IDE); // memory or i/o mode
  wire [7:0]  heads_w  = geom_r[7:0];
  wire [15:0] spt_w    = geom_r[31:16];

  // ==========================================================================
  // word 0: signature, or the bit-significant form in true ide only
  wire [3:0] ret_hi_w = keep_ret ? idr_pkg::IDR_RETIRED_HI : 4'h0; // see R18
  wire [5:0] ret_lo_w = keep_ret ? idr_pkg::IDR_RETIRED_LO : 6'h00; // see R23
  // flag 0h, retired bits, media bit, fixed-device bit set; see R16 R19 R20
  wire [15:0] alt_word0 = {4'h0, ret_hi_w, media_rem, 1'b1, ret_lo_w};
  // pc card modes always report the signature; see R14 R17
  wire [15:0] word0_w   = (alt_en & ~pccard_w) ? alt_word0 : SIGNATURE;
  wire        flag0_w   = (word0_w[15:12] == 4'h0);   // see R15

  // ==========================================================================
  // command acceptance
  wire cmd_wr   = wr_w & hit_cmd;
  wire is_ident = (pwdata[7:0] == idr_pkg::IDR_OP_IDENTIFY);
  wire drv_ok   = (pwdata[idr_pkg::IDR_CMD_DRIVE_BIT] == drive_id);
  // identify to this card while idle starts the sequence; see R1
  wire start_w  = cmd_wr & is_ident & drv_ok & (state_r == idr_pkg::IDR_IDLE);
  // other opcode to this card while idle is refused
  wire refuse_w = cmd_wr & ~is_ident & drv_ok & (state_r == idr_pkg::IDR_IDLE);

  // ==========================================================================
  // parameter block word lookup
  function automatic logic [15:0] word_at(input logic [7:0] w);
    logic [15:0] v;
    logic [7:0]  j;
    v = 16'h0000;                    // reserved, obsolete, 80-81, 168-255
    j = 8'h00;
    if (w >= 8'd10 && w <= 8'd19) begin
      // serial, field padded in the parameter itself; see R11
      j = w - 8'd10;
      v = SERIAL[16 * (9 - int'(j)) +: 16];
    end else if (w >= 8'd23 && w <= 8'd26) begin
      // firmware, first character in high byte; see R9
      j = w - 8'd23;
      v = FIRMWARE[16 * (3 - int'(j)) +: 16];
    end else if (w >= 8'd27 && w <= 8'd46) begin
      // model, first character in high byte; see R10
      j = w - 8'd27;
      v = MODEL[16 * (19 - int'(j)) +: 16];
    end else begin
      unique case (w)
        8'd0:  v = word0_w;
        8'd1:  v = cyl_r;
        8'd3:  v = {8'h00, heads_w};                            // see R21
        8'd6:  v = spt_w;
        8'd7:  v = cap_r[31:16];                                 // see R6
        8'd8:  v = cap_r[15:0];                                  // see R6
        8'd22: v = idr_pkg::IDR_ECC_COUNT;                       // see R8
        8'd47: v = {idr_pkg::IDR_MULT_MAX_HI, mult_r[7:0]};
        8'd49: v = {idr_pkg::IDR_CAPAB_HI, 8'h00};               // see R21
        8'd51: v = {mult_r[23:16], 8'h00};                       // see R21
        8'd53: v = idr_pkg::IDR_VALIDITY;
        8'd54: v = cyl_r;
        8'd55: v = {8'h00, heads_w};
        8'd56: v = spt_w;
        8'd57: v = cap_r[15:0];                                  // see R7
        8'd58: v = cap_r[31:16];                                 // see R7
        8'd59: v = {idr_pkg::IDR_MULT_VALID, mult_r[15:8]};      // see R12
        8'd60: v = cap_r[15:0];
        8'd61: v = cap_r[31:16];
        8'd63: v = pccard_w ? 16'h0000 : dma_r[15:0];            // see R13
        8'd64: v = {8'h00, mult_r[31:24]};                       // see R21
        8'd65: v = pccard_w ? 16'h0000 : dma_r[31:16];           // see R13
        8'd66: v = pccard_w ? 16'h0000 : dma_r[31:16];           // see R13
        8'd67: v = PIO_CYC_NOFC;
        8'd68: v = PIO_CYC_FC;
        8'd83: v = {13'h0000, flag0_w, 2'b00};                   // see R15
        default: v = 16'h0000;                                   // see R3 R5
      endcase
    end
    return v;
  endfunction

  // word at the current index; a process, so that writes to the card values
  // also refresh it while the index stands still (word 0 after a cfg write)
  logic [15:0] cur_word;
  always_comb begin
    cur_word = word_at(idx_r);
  end

  // ==========================================================================
  // read data mux, evaluated during the setup cycle
  wire [31:0] stat_w = {16'h0000, idx_r, busy_r, ~busy_r, 2'b00, drq_r, 2'b00, err_r};
  wire [31:0] rd_w =
      hit_stat ? stat_w :
      hit_data ? {16'h0000, drq_r ? cur_word : 16'h0000} :
      hit_cfg  ? {24'h000000, cfg_r} :
      hit_cap  ? cap_r :
      hit_cyl  ? {16'h0000, cyl_r} :
      hit_geom ? geom_r :
      hit_mult ? mult_r :
      hit_dma  ? dma_r : 32'h0000_0000;

  // ==========================================================================
  // sequence: busy while preparing, then data request for 256 words; see R2
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    prep_nxt  = prep_r;
    err_nxt   = err_r;
    unique case (state_r)
      idr_pkg::IDR_IDLE: begin
        if (start_w) begin
          state_nxt = idr_pkg::IDR_PREP;
          prep_nxt  = 4'(idr_pkg::IDR_PREP_CYC - 1);
          idx_nxt   = 8'h00;
          err_nxt   = 1'b0;
        end else if (refuse_w) begin
          err_nxt = 1'b1;
        end
      end
      idr_pkg::IDR_PREP: begin
        // count down the buffer preparation time
        if (prep_r == 4'h0) begin
          state_nxt = idr_pkg::IDR_XFER;
        end else begin
          prep_nxt = prep_r - 4'h1;
        end
      end
      idr_pkg::IDR_XFER: begin
        // each data read hands over one word; last one ends the block
        if (pop_w) begin
          idx_nxt = idx_r + 8'h01;
          if (idx_r == 8'(idr_pkg::IDR_WORDS - 1)) begin
            state_nxt = idr_pkg::IDR_IDLE;
          end
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= idr_pkg::IDR_IDLE;
      idx_r   <= 8'h00;
      prep_r  <= 4'h0;
      err_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      prep_r  <= prep_nxt;
      err_r   <= err_nxt;
    end
  end

  // status flags as registered outputs, next value of state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      drq_r  <= 1'b0;
    end else begin
      busy_r <= (state_nxt == idr_pkg::IDR_PREP);   // see R2
      drq_r  <= (state_nxt == idr_pkg::IDR_XFER);   // see R2
    end
  end

  // ==========================================================================
  // software-written card values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r  <= idr_pkg::IDR_CFG_RST;
      cap_r  <= idr_pkg::IDR_CAP_RST;
      cyl_r  <= idr_pkg::IDR_CYL_RST;
      geom_r <= idr_pkg::IDR_GEOM_RST;
      mult_r <= idr_pkg::IDR_MULT_RST;
      dma_r  <= idr_pkg::IDR_DMA_RST;
    end else if (wr_w) begin
      if (hit_cfg) begin
        cfg_r <= pwdata[7:0];
      end
      if (hit_cap) begin
        cap_r <= pwdata;
      end
      if (hit_cyl) begin
        cyl_r <= pwdata[15:0];
      end
      if (hit_geom) begin
        geom_r <= pwdata;
      end
      if (hit_mult) begin
        mult_r <= pwdata;
      end
      if (hit_dma) begin
        dma_r <= pwdata;
      end
    end
  end

  // ==========================================================================
  // apb answer: data and ready loaded at the setup edge, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      if (setup_w) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_w;
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign busy     = busy_r;
  assign data_req = drq_r;

  // ==========================================================================
  // checks
  property p_r1;
    @(posedge pclk) disable iff (!presetn)
      start_w |=> busy_r && !drq_r;
  endproperty
  a_r1: assert property (p_r1) else $error("identify did not raise busy"); // see R1

  property p_r2;
    @(posedge pclk) disable iff (!presetn)
      start_w |=> busy_r ##9 busy_r ##1 (drq_r && !busy_r);
  endproperty
  a_r2: assert property (p_r2) else $error("busy then data request order wrong"); // see R2

  property p_r5;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && (idx_r == 8'd80 || idx_r == 8'd81))
      |=> prdata_r == 32'h0000_0000;
  endproperty
  a_r5: assert property (p_r5) else $error("version words not zero"); // see R5

  property p_r3;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && idx_r >= 8'd168)
      |=> prdata_r[15:0] == 16'h0000;
  endproperty
  a_r3: assert property (p_r3) else $error("reserved tail word not zero"); // see R3

  property p_r6;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && idx_r == 8'd7)
      |=> prdata_r[15:0] == cap_r[31:16];
  endproperty
  a_r6: assert property (p_r6) else $error("word 7 not high capacity half"); // see R6

  property p_r7;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && idx_r == 8'd57)
      |=> prdata_r[15:0] == cap_r[15:0];
  endproperty
  a_r7: assert property (p_r7) else $error("word 57 not low capacity half"); // see R7

  property p_r12;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && idx_r == 8'd59)
      |=> prdata_r[15:8] == 8'h01 && prdata_r[7:0] == $past(mult_r[15:8]);
  endproperty
  a_r12: assert property (p_r12) else $error("word 59 wrong"); // see R12

  property p_r13;
    @(posedge pclk) disable iff (!presetn)
      (setup_w && !pwrite && hit_data && drq_r && pccard_w
       && (idx_r == 8'd63 || idx_r == 8'd65 || idx_r == 8'd66))
      |=> prdata_r == 32'h0000_0000;
  endproperty
  a_r13: assert property (p_r13) else $error("dma word not zero in pc card mode"); // see R13

  property p_r14;
    @(posedge pclk) disable iff (!presetn)
      word0_w[15:12] == 4'h8 || word0_w[15:12] == 4'h0;
  endproperty
  a_r14: assert property (p_r14) else $error("word 0 flag illegal"); // see R14

  property p_r17;
    @(posedge pclk) disable iff (!presetn)
      pccard_w |-> word0_w == SIGNATURE;
  endproperty
  a_r17: assert property (p_r17) else $error("pc card mode word 0 not signature"); // see R17

  property p_r23;
    @(posedge pclk) disable iff (!presetn)
      flag0_w |-> !word0_w[2] && !word0_w[0] && word0_w[6];
  endproperty
  a_r23: assert property (p_r23) else $error("word 0 low bits wrong"); // see R23

endmodule

// ### idr_identify_tb.sv
// idr_identify_tb: random card values, identify runs, word by word compare.
// assumes idr_pkg and idr_identify; host traffic comes from idr_host_model.
`timescale 1ns/1ps
module idr_identify_tb;
  // ==========================================================================
  // card strings and signature
  localparam logic [159:0] SER = {"          ", "SN01234567"};
  localparam logic [63:0]  FW  = "FW 2.10 ";
  localparam logic [319:0] MDL = {"TEST CARD", {31{8'h20}}};
  localparam logic [15:0]  SIG = 16'h8a5c; // arbitrary value, flag 8h

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        data_req;
  logic [31:0] rdv;      // last read data
  logic        errv;     // last error flag
  logic [7:0]  cfg;      // card values now loaded
  logic [31:0] cap;
  logic [15:0] cyl;
  logic [31:0] geom;
  logic [31:0] mult;
  logic [31:0] dma;
  int          fail_count;
  int          n_checks;
  int          cyc;

  idr_identify #(.SIGNATURE(SIG), .SERIAL(SER), .FIRMWARE(FW), .MODEL(MDL)) u_idr_identify (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .data_req(data_req));

  idr_host_model u_idr_host_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================================
  // compare, bus and closing tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_idr_host_model.xfer(1'b1, a, d, rdv, errv);
  endtask

  task automatic rd(input logic [7:0] a);
    u_idr_host_model.xfer(1'b0, a, 32'h0, rdv, errv);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // expected word: mask in the upper half, value in the lower
  function automatic logic [31:0] exp_word(input int n);
    logic        pc;
    logic [15:0] v;
    logic [15:0] m;
    pc = (cfg[2:1] != idr_pkg::IDR_MODE_IDE);
    v  = 16'h0000;
    m  = 16'hffff;
    case (n) inside
      0: v = (pc || !cfg[3]) ? SIG : {4'h0, cfg[4] ? 4'h4 : 4'h0, cfg[5], 1'b1,
                                       cfg[4] ? 6'h0a : 6'h00};
      1: v = cyl;
      3: v = {8'h00, geom[7:0]};
      6: v = geom[31:16];
      7, 61: v = cap[31:16];
      8, 60: v = cap[15:0];
      [10:19]: v = SER[159 - 16 * (n - 10) -: 16];
      22: v = idr_pkg::IDR_ECC_COUNT;
      [23:26]: v = FW[63 - 16 * (n - 23) -: 16];
      [27:46]: v = MDL[319 - 16 * (n - 27) -: 16];
      47: v = {8'h80, mult[7:0]};
      49: v = 16'h0200;
      51: v = {mult[23:16], 8'h00};
      53: v = 16'h0001;
      54: v = cyl;
      55: v = {8'h00, geom[7:0]};
      56: v = geom[31:16];
      57: v = cap[15:0];
      58: v = cap[31:16];
      59: v = {8'h01, mult[15:8]};
      63: v = pc ? 16'h0000 : dma[15:0];
      64: v = {8'h00, mult[31:24]};
      65, 66: v = pc ? 16'h0000 : dma[31:16];
      67, 68: v = 16'h0078;
      83: begin
        v = (!pc && cfg[3]) ? 16'h0004 : 16'h0000;
        m = 16'h0004;
      end
      4, 5, 9, 20, 21, 52, [82:91], 128, 160, 163, 164: m = 16'h0000;
      default: v = 16'h0000;
    endcase
    return {m, v & m};
  endfunction

  // ==========================================================================
  // one identify run with fresh random card values
  task automatic run_identify(input logic [7:0] c);
    logic [31:0] e;
    int          n;
    cfg  = c;
    cap  = $urandom;
    cyl  = 16'($urandom);
    geom = $urandom;
    mult = {6'h00, 2'($urandom), 8'($urandom % 3), 16'($urandom)};
    dma  = $urandom;
    wr(idr_pkg::IDR_CFG_OFS, {24'h0, c});
    wr(idr_pkg::IDR_CAP_OFS, cap);
    wr(idr_pkg::IDR_CYL_OFS, {16'h0, cyl});
    wr(idr_pkg::IDR_GEOM_OFS, geom);
    wr(idr_pkg::IDR_MULT_OFS, mult);
    wr(idr_pkg::IDR_DMA_OFS, dma);
    u_idr_host_model.identify(c[0], idr_pkg::IDR_OP_IDENTIFY);
    #1;
    check({31'h0, busy}, 32'h1, "busy");
    n = 0;
    while (data_req !== 1'b1 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(32'(n), 32'(idr_pkg::IDR_PREP_CYC), "prep");
    check({30'h0, busy, data_req}, 32'h1, "drq");
    for (int w = 0; w < idr_pkg::IDR_WORDS; w++) begin
      rd(idr_pkg::IDR_DATA_OFS);
      e = exp_word(w);
      check(rdv & {16'hffff, e[31:16]}, {16'h0, e[15:0]}, "word");
    end
    #1;
    check({31'h0, data_req}, 32'h0, "drq end");
    rd(idr_pkg::IDR_DATA_OFS);
    check(rdv, 32'h0, "extra read");
    $display("test identify cfg %h done", c);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0] cfgs [6];
    presetn    = 1'b0;
    fail_count = 0;
    n_checks   = 0;
    cyc        = 0;
    void'($urandom(32'h9dfe4181));
    // alternate word 0 cases serve a host that boots from the card
    cfgs = '{8'h00, 8'h18, 8'h08, 8'h38, 8'h1a, 8'h2c};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(idr_pkg::IDR_MULT_OFS);
    check(rdv, idr_pkg::IDR_MULT_RST, "mult reset");
    rd(idr_pkg::IDR_CFG_OFS);
    check(rdv, {24'h0, idr_pkg::IDR_CFG_RST}, "cfg reset");
    rd(8'h40);
    check({rdv[30:0], errv}, 32'h1, "unmapped");
    $display("test reset and map done");
    // wrong drive bit is ignored, wrong opcode flags an error
    wr(idr_pkg::IDR_CFG_OFS, 32'h0);
    u_idr_host_model.identify(1'b1, idr_pkg::IDR_OP_IDENTIFY);
    rd(idr_pkg::IDR_STAT_OFS);
    check(rdv & 32'h89, 32'h0, "other drive");
    u_idr_host_model.identify(1'b0, 8'h20);
    rd(idr_pkg::IDR_STAT_OFS);
    check(rdv & 32'h89, 32'h1, "bad opcode");
    $display("test refusals done");
    foreach (cfgs[i]) run_identify(cfgs[i] | 8'($urandom % 2));
    rd(idr_pkg::IDR_STAT_OFS);
    check(rdv & 32'h89, 32'h0, "err cleared");
    test_done();
  end
endmodule

// ### idr_pkg.sv
// idr_pkg: constants shared by the identify parameter block responder.
// assumes a single pclk domain at 10 MHz and an APB register port.
package idr_pkg;

  // ==========================================================================
  // register byte offsets on the APB port
  localparam logic [7:0] IDR_CMD_OFS    = 8'h00; // opcode and drive/head byte
  localparam logic [7:0] IDR_STAT_OFS   = 8'h04; // busy, data request, word index
  localparam logic [7:0] IDR_DATA_OFS   = 8'h08; // data port, one word per read
  localparam logic [7:0] IDR_CFG_OFS    = 8'h0c; // drive id, mode, word 0 choice
  localparam logic [7:0] IDR_CAP_OFS    = 8'h10; // sectors per card
  localparam logic [7:0] IDR_CYL_OFS    = 8'h14; // cylinders
  localparam logic [7:0] IDR_GEOM_OFS   = 8'h18; // heads and sectors per track
  localparam logic [7:0] IDR_MULT_OFS   = 8'h1c; // multiple counts, pio modes
  localparam logic [7:0] IDR_DMA_OFS    = 8'h20; // dma modes and cycle time

  // ==========================================================================
  // field positions
  localparam int IDR_CMD_DRIVE_BIT  = 12; // drive bit of the drive/head byte
  localparam int IDR_CFG_DRIVE_BIT  = 0;  // drive number this card answers
  localparam int IDR_CFG_MODE_LSB   = 1;  // two-bit operating mode
  localparam int IDR_CFG_ALT_BIT    = 3;  // use bit-significant word 0 in ide
  localparam int IDR_CFG_KEEP_BIT   = 4;  // keep retired bits in word 0
  localparam int IDR_CFG_MEDIA_BIT  = 5;  // media removable during operation
  localparam int IDR_ST_BUSY_BIT    = 7;
  localparam int IDR_ST_RDY_BIT     = 6;
  localparam int IDR_ST_DRQ_BIT     = 3;
  localparam int IDR_ST_ERR_BIT     = 0;
  localparam int IDR_ST_IDX_LSB     = 8;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  IDR_CFG_RST  = 8'h00;
  localparam logic [31:0] IDR_CAP_RST  = 32'h0000_0000;
  localparam logic [15:0] IDR_CYL_RST  = 16'h0000;
  localparam logic [31:0] IDR_GEOM_RST = 32'h0000_0000;
  localparam logic [31:0] IDR_MULT_RST = 32'h0000_0001;
  localparam logic [31:0] IDR_DMA_RST  = 32'h0000_0000;

  // ==========================================================================
  // commands, modes and fixed word values
  localparam logic [7:0]  IDR_OP_IDENTIFY = 8'hec;
  localparam logic [1:0]  IDR_MODE_IDE    = 2'd0;
  localparam logic [1:0]  IDR_MODE_MEM    = 2'd1;
  localparam logic [1:0]  IDR_MODE_IO     = 2'd2;
  localparam logic [3:0]  IDR_RETIRED_HI  = 4'h4;   // retired bits 11:8 kept
  localparam logic [5:0]  IDR_RETIRED_LO  = 6'h0a;  // retired bits 5:0 kept
  localparam logic [15:0] IDR_ECC_COUNT   = 16'h0004;
  localparam logic [7:0]  IDR_MULT_MAX_HI = 8'h80;
  localparam logic [7:0]  IDR_MULT_VALID  = 8'h01;
  localparam logic [7:0]  IDR_CAPAB_HI    = 8'h02;  // lba supported
  localparam logic [15:0] IDR_VALIDITY    = 16'h0001;
  localparam int          IDR_WORDS       = 256;

  // ==========================================================================
  // timing: preparation time of the buffer before data request
  localparam int IDR_CLK_NS  = 100;
  localparam int IDR_PREP_NS = 1000;
  localparam int IDR_PREP_CYC = (IDR_PREP_NS + IDR_CLK_NS - 1) / IDR_CLK_NS;

  // transfer states
  typedef enum logic [1:0] {IDR_IDLE, IDR_PREP, IDR_XFER} idr_state_t;

endpackage
